// file: logic/agp_pkg.sv
package agp_pkg;

  // ==========================================================================
  // Link words
  // ==========================================================================
  typedef struct packed {
    logic [7:0]  rsvd;
    logic [3:0]  addr;
    logic [7:0]  nid;
    logic [11:0] verb;
    logic [7:0]  payload;
  } agp_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        unsol;
    logic [1:0]  rsvd;
    logic [31:0] data;
  } agp_resp_t;

  localparam int          CMD_W   = 40;
  localparam int          RESP_W  = 36;
  localparam logic [7:0]  NODE_ID = 8'h01;

  // ==========================================================================
  // Verbs and parameter selectors
  // ==========================================================================
  localparam logic [11:0] VERB_GET_PARAM = 12'hf00;
  localparam logic [11:0] VERB_GET_POWER = 12'hf05;
  localparam logic [11:0] VERB_SET_POWER = 12'h705;
  localparam logic [11:0] VERB_GET_UNSOL = 12'hf08;
  localparam logic [11:0] VERB_SET_UNSOL = 12'h708;
  localparam logic [11:0] VERB_GET_DATA  = 12'hf15;
  localparam logic [11:0] VERB_SET_DATA  = 12'h715;
  localparam logic [11:0] VERB_GET_EN    = 12'hf16;
  localparam logic [11:0] VERB_SET_EN    = 12'h716;
  localparam logic [11:0] VERB_GET_DIR   = 12'hf17;
  localparam logic [11:0] VERB_SET_DIR   = 12'h717;

  localparam logic [7:0]  PAR_FORMAT  = 8'h0a;
  localparam logic [7:0]  PAR_STREAM  = 8'h0b;
  localparam logic [7:0]  PAR_IN_AMP  = 8'h0d;
  localparam logic [7:0]  PAR_POWER   = 8'h0f;
  localparam logic [7:0]  PAR_PINS    = 8'h11;
  localparam logic [7:0]  PAR_OUT_AMP = 8'h12;

  // ==========================================================================
  // Capability words
  // ==========================================================================
  localparam logic [31:0] CAP_FORMAT  = 32'h000e07e0;
  localparam logic [31:0] CAP_STREAM  = 32'h00000001;
  localparam logic [31:0] CAP_IN_AMP  = 32'h00050f00;
  localparam logic [31:0] CAP_POWER   = 32'h0000000f;
  localparam logic [31:0] CAP_PINS    = 32'hc0000005;
  localparam logic [31:0] CAP_OUT_AMP = 32'h80027f7f;
  localparam logic [31:0] RESP_ZERO   = 32'h00000000;

  // ==========================================================================
  // Control fields
  // ==========================================================================
  localparam int PIN_COUNT    = 5;
  localparam int UNSOL_EN_BIT = 7;
  localparam int TAG_W        = 6;
  localparam int TAG_LSB      = 26;
  localparam int PWR_ACT_LSB  = 4;
  localparam int DOMAIN_COUNT = 7;

  typedef enum logic [1:0] {
    PWR_D0 = 2'h0,
    PWR_D1 = 2'h1,
    PWR_D2 = 2'h2,
    PWR_D3 = 2'h3
  } agp_pwr_t;

  localparam agp_pwr_t PWR_RESET = PWR_D3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_WAIT = 2'h3
  } agp_state_t;

  typedef struct packed {
    logic                    amp_down;
    logic [DOMAIN_COUNT-1:0] domain_down;
  } agp_power_map_t;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam longint CLK_HZ         = 50000000;
  localparam longint PWR_WAKE_MS    = 10;
  localparam int     PWR_SETTLE_CYC = int'(PWR_WAKE_MS * CLK_HZ / 1000);
  localparam int     SETTLE_W       = 20;

  function automatic agp_power_map_t power_map(input agp_pwr_t lvl);
    agp_power_map_t m;
    m = '0;
    case (lvl)
      PWR_D0: m = '0;
      PWR_D1: m.domain_down = 7'h03;
      PWR_D2: m = '{amp_down: 1'h1, domain_down: 7'h47};
      PWR_D3: m = '{amp_down: 1'h1, domain_down: 7'h6f};
      default: m = '0;
    endcase
    return m;
  endfunction

endpackage

// file: logic/agp_sync2.sv
`timescale 1ns/1ps
module agp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } agp_sync_t;

  agp_sync_t r_reg;
  agp_sync_t r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule

// file: logic/agp_word_xfer.sv
`timescale 1ns/1ps
module agp_word_xfer #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_busy,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst,
  input  wire logic         dst_hold,
  output logic              dst_valid,
  output logic      [W-1:0] dst_data
);
  typedef struct packed {
    logic         req;
    logic [W-1:0] data;
  } agp_xsrc_t;

  typedef struct packed {
    logic         ack;
    logic         valid;
    logic [W-1:0] data;
  } agp_xdst_t;

  agp_xsrc_t s_reg;
  agp_xsrc_t s_next;
  agp_xdst_t d_reg;
  agp_xdst_t d_next;
  logic      ack_s;
  logic      req_s;

  // ==========================================================================
  // Source side: the word stays frozen until the acknowledge returns.
  // ==========================================================================
  assign src_busy = s_reg.req ^ ack_s;

  always_comb begin
    s_next = s_reg;
    if (src_valid && !src_busy) begin
      s_next.req  = ~s_reg.req;
      s_next.data = src_data;
    end
  end

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  agp_sync2 #(.W(1)) u_ack_sync (
    .clk (src_clk),
    .rst (src_rst),
    .d   (d_reg.ack),
    .q   (ack_s)
  );

  // ==========================================================================
  // Destination side.
  // ==========================================================================
  agp_sync2 #(.W(1)) u_req_sync (
    .clk (dst_clk),
    .rst (dst_rst),
    .d   (s_reg.req),
    .q   (req_s)
  );

  always_comb begin
    d_next       = d_reg;
    d_next.valid = 1'h0;
    if ((req_s != d_reg.ack) && !dst_hold) begin
      d_next.ack   = req_s;
      d_next.valid = 1'h1;
      d_next.data  = s_reg.data;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign dst_valid = d_reg.valid;
  assign dst_data  = d_reg.data;
endmodule

// file: logic/agp_node.sv
`timescale 1ns/1ps
module agp_node #(
  parameter logic [3:0] CODEC_ADDR        = 4'h0,
  parameter int         PWR_SETTLE_CYCLES = agp_pkg::PWR_SETTLE_CYC
) (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  link_clk,
  input  wire logic                                  link_rst,
  input  wire logic                                  frame_sync,
  input  wire logic                                  cmd_valid,
  input  wire agp_pkg::agp_cmd_t                     cmd_word,
  output agp_pkg::agp_resp_t                         resp_word,
  output logic                                       resp_valid,
  output logic                                       status_change_req,
  input  wire logic [agp_pkg::PIN_COUNT-1:0]         pin_in,
  output logic      [agp_pkg::PIN_COUNT-1:0]         pin_out,
  output logic      [agp_pkg::PIN_COUNT-1:0]         pin_oe_n,
  input  wire logic [agp_pkg::PIN_COUNT-1:0]         pin_wake_mask,
  input  wire logic [agp_pkg::PIN_COUNT-1:0]         pin_unsol_mask,
  output logic      [agp_pkg::DOMAIN_COUNT-1:0]      power_domain_down,
  output logic                                       external_amp_powerdown,
  output agp_pkg::agp_pwr_t                          actual_power_level
);
  localparam int PN = agp_pkg::PIN_COUNT;

  typedef struct packed {
    agp_pkg::agp_state_t               fsm;
    agp_pkg::agp_pwr_t                 pwr_req;
    agp_pkg::agp_pwr_t                 pwr_act;
    logic [agp_pkg::SETTLE_W-1:0]      settle_cnt;
    logic                              unsol_en;
    logic [agp_pkg::TAG_W-1:0]         tag;
    logic [PN-1:0]                     data;
    logic [PN-1:0]                     en;
    logic [PN-1:0]                     dir;
    logic [PN-1:0]                     prev;
    logic                              unsol_pend;
    logic                              wake_tgl;
    logic                              send;
    agp_pkg::agp_resp_t                resp;
    logic [PN-1:0]                     pin_out;
    logic [PN-1:0]                     pin_oe_n;
    agp_pkg::agp_power_map_t           pmap;
  } agp_core_t;

  typedef struct packed {
    logic                sol_full;
    agp_pkg::agp_resp_t  sol;
    logic                uns_full;
    agp_pkg::agp_resp_t  uns;
    logic                resp_valid;
    agp_pkg::agp_resp_t  resp_word;
    logic                wake_seen;
    logic                status_req;
  } agp_link_t;

  localparam agp_core_t CORE_RST = '{
    fsm: agp_pkg::ST_IDLE, pwr_req: agp_pkg::PWR_RESET, pwr_act: agp_pkg::PWR_RESET,
    pin_oe_n: '1, pmap: agp_pkg::power_map(agp_pkg::PWR_RESET), default: '0};

  agp_core_t          c_reg;
  agp_core_t          c_next;
  agp_link_t          l_reg;
  agp_link_t          l_next;
  agp_pkg::agp_cmd_t  cmd_rx;
  logic               cmd_rx_valid;
  logic               cmd_busy;
  logic               rsp_busy;
  agp_pkg::agp_resp_t rsp_rx;
  logic               rsp_rx_valid;
  logic [PN-1:0]      pin_s;
  logic               uns_full_s;
  logic               wake_s;
  logic               cmd_hit;
  logic [PN-1:0]      pin_change;
  logic [PN-1:0]      pin_read;

  // ==========================================================================
  // Crossings
  // ==========================================================================
  // Commands are dropped while the previous one is still crossing; the host
  // issues at most one per frame, so this never happens in normal use.
  agp_word_xfer #(.W(agp_pkg::CMD_W)) u_cmd_xfer (
    .src_clk   (link_clk),
    .src_rst   (link_rst),
    .src_valid (cmd_valid),
    .src_data  (cmd_word),
    .src_busy  (cmd_busy),
    .dst_clk   (clk),
    .dst_rst   (sys_rst),
    .dst_hold  (c_reg.fsm != agp_pkg::ST_IDLE),
    .dst_valid (cmd_rx_valid),
    .dst_data  (cmd_rx)
  );

  agp_word_xfer #(.W(agp_pkg::RESP_W)) u_rsp_xfer (
    .src_clk   (clk),
    .src_rst   (sys_rst),
    .src_valid (c_reg.send),
    .src_data  (c_reg.resp),
    .src_busy  (rsp_busy),
    .dst_clk   (link_clk),
    .dst_rst   (link_rst),
    .dst_hold  (1'h0),
    .dst_valid (rsp_rx_valid),
    .dst_data  (rsp_rx)
  );

  agp_sync2 #(.W(PN)) u_pin_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   (pin_in),
    .q   (pin_s)
  );

  agp_sync2 #(.W(1)) u_uns_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   (l_reg.uns_full),
    .q   (uns_full_s)
  );

  agp_sync2 #(.W(1)) u_wake_sync (
    .clk (link_clk),
    .rst (link_rst),
    .d   (c_reg.wake_tgl),
    .q   (wake_s)
  );

  // ==========================================================================
  // Verb execution and pin logic
  // ==========================================================================
  assign cmd_hit    = cmd_rx_valid && (cmd_rx.nid == agp_pkg::NODE_ID)
                      && (cmd_rx.addr == CODEC_ADDR);
  assign pin_change = (pin_s ^ c_reg.prev) & c_reg.en & ~c_reg.dir;
  assign pin_read   = (c_reg.dir & c_reg.data) | (~c_reg.dir & pin_s);

  always_comb begin
    c_next      = c_reg;
    c_next.send = 1'h0;
    c_next.prev = pin_s;
    if ((pin_change & pin_wake_mask) != '0) begin
      c_next.wake_tgl = ~c_reg.wake_tgl;
    end
    if (c_reg.pwr_act != c_reg.pwr_req) begin
      if (c_reg.settle_cnt == agp_pkg::SETTLE_W'(PWR_SETTLE_CYCLES - 1)) begin
        c_next.pwr_act    = c_reg.pwr_req;
        c_next.settle_cnt = '0;
      end else begin
        c_next.settle_cnt = c_reg.settle_cnt + 1'h1;
      end
    end else begin
      c_next.settle_cnt = '0;
    end
    c_next.pmap = agp_pkg::power_map(c_reg.pwr_act);
    case (c_reg.fsm)
      agp_pkg::ST_IDLE: begin
        if (cmd_hit) begin
          c_next.resp = '{valid: 1'h1, unsol: 1'h0, default: '0};
          case (cmd_rx.verb)
            agp_pkg::VERB_GET_PARAM: begin
              case (cmd_rx.payload)
                agp_pkg::PAR_FORMAT:  c_next.resp.data = agp_pkg::CAP_FORMAT;
                agp_pkg::PAR_STREAM:  c_next.resp.data = agp_pkg::CAP_STREAM;
                agp_pkg::PAR_IN_AMP:  c_next.resp.data = agp_pkg::CAP_IN_AMP;
                agp_pkg::PAR_POWER:   c_next.resp.data = agp_pkg::CAP_POWER;
                agp_pkg::PAR_PINS:    c_next.resp.data = agp_pkg::CAP_PINS;
                agp_pkg::PAR_OUT_AMP: c_next.resp.data = agp_pkg::CAP_OUT_AMP;
                default:              c_next.resp.data = agp_pkg::RESP_ZERO;
              endcase
            end
            agp_pkg::VERB_GET_POWER: begin
              c_next.resp.data[1:0] = c_reg.pwr_req;
              c_next.resp.data[agp_pkg::PWR_ACT_LSB +: 2] = c_reg.pwr_act;
            end
            agp_pkg::VERB_SET_POWER: begin
              c_next.pwr_req = agp_pkg::agp_pwr_t'(cmd_rx.payload[1:0]);
            end
            agp_pkg::VERB_GET_UNSOL: begin
              c_next.resp.data[agp_pkg::UNSOL_EN_BIT] = c_reg.unsol_en;
              c_next.resp.data[agp_pkg::TAG_W-1:0]    = c_reg.tag;
            end
            agp_pkg::VERB_SET_UNSOL: begin
              c_next.unsol_en = cmd_rx.payload[agp_pkg::UNSOL_EN_BIT];
              c_next.tag      = cmd_rx.payload[agp_pkg::TAG_W-1:0];
            end
            agp_pkg::VERB_GET_DATA: c_next.resp.data[PN-1:0] = pin_read;
            agp_pkg::VERB_SET_DATA: c_next.data = cmd_rx.payload[PN-1:0];
            agp_pkg::VERB_GET_EN:   c_next.resp.data[PN-1:0] = c_reg.en;
            agp_pkg::VERB_SET_EN:   c_next.en = cmd_rx.payload[PN-1:0];
            agp_pkg::VERB_GET_DIR:  c_next.resp.data[PN-1:0] = c_reg.dir;
            agp_pkg::VERB_SET_DIR:  c_next.dir = cmd_rx.payload[PN-1:0];
            default:                c_next.resp.data = agp_pkg::RESP_ZERO;
          endcase
          c_next.fsm = agp_pkg::ST_SEND;
        end else if (c_reg.unsol_pend && c_reg.unsol_en && !uns_full_s && !rsp_busy) begin
          c_next.resp = '{valid: 1'h1, unsol: 1'h1, default: '0};
          c_next.resp.data[agp_pkg::TAG_LSB +: agp_pkg::TAG_W] = c_reg.tag;
          c_next.resp.data[PN-1:0] = pin_read;
          c_next.unsol_pend = 1'h0;
          c_next.fsm        = agp_pkg::ST_SEND;
        end
      end
      agp_pkg::ST_SEND: begin
        c_next.send = 1'h1;
        c_next.fsm  = agp_pkg::ST_WAIT;
      end
      agp_pkg::ST_WAIT: begin
        if (!rsp_busy && !c_reg.send) begin
          c_next.fsm = agp_pkg::ST_IDLE;
        end
      end
      default: c_next.fsm = agp_pkg::ST_IDLE;
    endcase
    // A new pin event wins over the clear taken when a report is launched.
    if (((pin_change & pin_unsol_mask) != '0) && c_reg.unsol_en) begin
      c_next.unsol_pend = 1'h1;
    end
    c_next.pin_out  = c_reg.data;
    c_next.pin_oe_n = ~(c_reg.en & c_reg.dir);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_reg <= CORE_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  assign pin_out                = c_reg.pin_out;
  assign pin_oe_n               = c_reg.pin_oe_n;
  assign power_domain_down      = c_reg.pmap.domain_down;
  assign external_amp_powerdown = c_reg.pmap.amp_down;
  assign actual_power_level     = c_reg.pwr_act;

  // ==========================================================================
  // Link side: one slot per response kind, solicited first at each frame.
  // ==========================================================================
  // The link clock may stop between frames, so nothing here waits on edges
  // outside frame_sync; a held slot simply goes out at the next frame.
  always_comb begin
    l_next            = l_reg;
    l_next.resp_valid = 1'h0;
    l_next.status_req = 1'h0;
    l_next.wake_seen  = wake_s;
    if (wake_s != l_reg.wake_seen) begin
      l_next.status_req = 1'h1;
    end
    if (frame_sync) begin
      if (l_reg.sol_full) begin
        l_next.resp_valid = 1'h1;
        l_next.resp_word  = l_reg.sol;
        l_next.sol_full   = 1'h0;
      end else if (l_reg.uns_full) begin
        l_next.resp_valid = 1'h1;
        l_next.resp_word  = l_reg.uns;
        l_next.uns_full   = 1'h0;
      end
    end
    if (rsp_rx_valid && !rsp_rx.unsol) begin
      l_next.sol_full = 1'h1;
      l_next.sol      = rsp_rx;
    end
    if (rsp_rx_valid && rsp_rx.unsol) begin
      l_next.uns_full = 1'h1;
      l_next.uns      = rsp_rx;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign resp_valid        = l_reg.resp_valid;
  assign resp_word         = l_reg.resp_word;
  assign status_change_req = l_reg.status_req;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_format_cap_word: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_hit && c_reg.fsm == agp_pkg::ST_IDLE && cmd_rx.verb == agp_pkg::VERB_GET_PARAM
     && cmd_rx.payload == agp_pkg::PAR_FORMAT)
    |=> (c_reg.resp.data == 32'h000e07e0) ##1 c_reg.send)
    else $error("format capability answer wrong");

  a_out_amp_word: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_hit && c_reg.fsm == agp_pkg::ST_IDLE && cmd_rx.verb == agp_pkg::VERB_GET_PARAM
     && cmd_rx.payload == agp_pkg::PAR_OUT_AMP)
    |=> c_reg.resp.data == 32'h80027f7f)
    else $error("output gain capability answer wrong");

  a_set_answers_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_hit && c_reg.fsm == agp_pkg::ST_IDLE && cmd_rx.verb == agp_pkg::VERB_SET_POWER)
    |=> c_reg.resp.data == '0 && c_reg.pwr_req == $past(cmd_rx.payload[1:0]))
    else $error("power set not stored or answer not zero");

  a_power_act_settle: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(c_reg.pwr_act)
    |-> $past(c_reg.settle_cnt) == agp_pkg::SETTLE_W'(PWR_SETTLE_CYCLES - 1))
    else $error("actual power level moved without settling");

  a_power_domain_map: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (c_reg.pwr_act == agp_pkg::PWR_D1 && $stable(c_reg.pwr_act))
    |=> power_domain_down == 7'h03 && !external_amp_powerdown)
    else $error("light power state domain map wrong");

  a_unsol_gate_tag: assert property (@(posedge clk) disable iff (sys_rst)
    (c_reg.send && c_reg.resp.unsol)
    |-> $past(c_reg.unsol_en, 2)
        && c_reg.resp.data[agp_pkg::TAG_LSB +: agp_pkg::TAG_W] == $past(c_reg.tag, 2))
    else $error("unsolicited report sent while disabled or with wrong tag");

  a_pin_disabled_hiz: assert property (@(posedge clk) disable iff (sys_rst)
    (!c_reg.en[0] || !c_reg.dir[0]) ##1 (!c_reg.en[0] || !c_reg.dir[0]) |-> pin_oe_n[0])
    else $error("pin driven while disabled or input");

  a_pin_output_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (c_reg.en[0] && c_reg.dir[0]) |=> !pin_oe_n[0] && pin_out[0] == $past(c_reg.data[0]))
    else $error("enabled output pin not driven");

  a_sol_next_frame: assert property (@(posedge link_clk) disable iff (link_rst)
    (frame_sync && l_reg.sol_full) |=> resp_valid && !resp_word.unsol)
    else $error("solicited answer missed its frame");
endmodule

// file: sim/agp_host.sv
`timescale 1ns/1ps
// ==========================================================================
// Host end of the link: frame timing, command slot and answer capture.
// ==========================================================================
module agp_host (
  input  wire logic               link_clk,
  input  wire logic               link_rst,
  output logic                    frame_sync,
  output logic                    cmd_valid,
  output agp_pkg::agp_cmd_t       cmd_word,
  input  wire agp_pkg::agp_resp_t resp_word,
  input  wire logic               resp_valid
);
  logic [5:0] slot_reg;
  initial begin
    cmd_valid = 1'h0;
    cmd_word  = '0;
  end
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) slot_reg <= 6'h00;
    else slot_reg <= slot_reg + 6'h01;
  end
  assign frame_sync = (slot_reg == 6'h3f);
  // Commands leave early in a frame so the crossing settles before the next sync.
  task automatic xfer(input logic [27:0] c, output logic [31:0] d, output logic ok);
    int f;
    f = 0;
    ok = 1'h0;
    d = '1;
    @(posedge link_clk iff slot_reg == 6'h01);
    cmd_valid <= 1'h1;
    cmd_word  <= {12'h000, c};
    @(posedge link_clk);
    cmd_valid <= 1'h0;
    cmd_word  <= ~{12'h000, c};
    for (int n = 0; n < 200; n++) begin
      @(posedge link_clk);
      if (resp_valid && resp_word[35:32] == 4'h8) begin
        d = resp_word.data;
        ok = (f == 1);
        n = 200;
      end
      f += frame_sync;
    end
  endtask
  task automatic unsol(output logic [31:0] d, output logic ok);
    ok = 1'h0;
    d = '1;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(posedge link_clk);
      if (resp_valid && resp_word[35:32] == 4'hc) begin
        d = resp_word.data;
        ok = 1'h1;
      end
    end
  endtask
endmodule

// file: sim/agp_node_test.sv
`timescale 1ns/1ps
module agp_node_test;
  logic               clk, sys_rst, link_clk, link_rst, fs, cv, scr, rv, amp, ok;
  agp_pkg::agp_cmd_t  cw;
  agp_pkg::agp_resp_t rw;
  agp_pkg::agp_pwr_t  act;
  logic [4:0]         pin_in, pin_out, oe_n, wm, um;
  logic [6:0]         dom;
  logic [31:0]        d;
  logic [31:0]        wakes = 32'h0;
  int                 err_count, checks, cyc;
  logic [51:0]        rows [12] = '{52'hf000a000e07e0, 52'hf000b00000001, 52'hf000d00050f00,
    52'hf000f0000000f, 52'hf0011c0000005, 52'hf001280027f7f, 52'hf009900000000,
    52'hf050000000033, 52'hf080000000000, 52'hf150000000000, 52'hf160000000000, 52'hf170000000000};
  agp_node #(.PWR_SETTLE_CYCLES(20)) agp_node_i (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .link_rst(link_rst), .frame_sync(fs), .cmd_valid(cv), .cmd_word(cw), .resp_word(rw),
    .resp_valid(rv), .status_change_req(scr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(oe_n), .pin_wake_mask(wm), .pin_unsol_mask(um), .power_domain_down(dom),
    .external_amp_powerdown(amp), .actual_power_level(act));
  agp_host agp_host_i (.link_clk(link_clk), .link_rst(link_rst), .frame_sync(fs),
    .cmd_valid(cv), .cmd_word(cw), .resp_word(rw), .resp_valid(rv));
  // ==========================================================================
  // Checking
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [19:0] vp, input logic [31:0] exp);
    agp_host_i.xfer({8'h01, vp}, d, ok);
    check(d, exp);
    check({31'h0, ok}, 32'h1);
  endtask
  // Every transition waits out the settle count before the readback.
  task automatic pw(input logic [7:0] p, input logic [7:0] rd, input logic [9:0] outs);
    cmd({12'h705, p}, 32'h0);
    repeat (40) @(posedge clk);
    cmd(20'hf0500, {24'h0, rd});
    check({22'h0, amp, dom, act}, {22'h0, outs});
  endtask
  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================================
  // Clocks, timeout and main sequence
  // ==========================================================================
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    link_clk = 1'h0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  always @(posedge link_clk) wakes += scr;
  initial begin
    {sys_rst, link_rst, pin_in, wm, um} = {2'h3, 15'h0};
    repeat (8) @(posedge clk);
    {sys_rst, link_rst} <= 2'h0;
    repeat (8) @(posedge clk);
    check({17'h0, amp, dom, act, oe_n}, 32'h77ff);
    foreach (rows[i]) cmd(rows[i][51:32], rows[i][31:0]);
    pw(8'h02, 8'h22, 10'h31e);
    pw(8'hfd, 8'h11, 10'h00d);
    pw(8'h00, 8'h00, 10'h000);
    @(posedge clk) pin_in <= 5'h0a;
    cmd(20'h7161f, 32'h0);
    cmd(20'h71703, 32'h0);
    cmd(20'h715e5, 32'h0);
    repeat (4) @(posedge clk);
    check({22'h0, oe_n, pin_out}, 32'h385);
    cmd(20'hf1500, 32'h09);
    cmd(20'hf1600, 32'h1f);
    cmd(20'hf1700, 32'h03);
    cmd(20'h708aa, 32'h0);
    cmd(20'hf0800, 32'haa);
    @(posedge clk) {um, wm} <= 10'h208;
    @(posedge clk) pin_in <= 5'h1a;
    agp_host_i.unsol(d, ok);
    check(d, 32'ha8000019);
    check(wakes, 32'h0);
    @(posedge clk) pin_in <= 5'h12;
    repeat (20) @(posedge link_clk);
    check(wakes, 32'h1);
    cmd(20'h7082a, 32'h0);
    @(posedge clk) pin_in <= 5'h02;
    agp_host_i.unsol(d, ok);
    check({31'h0, ok}, 32'h0);
    cmd(20'h71600, 32'h0);
    repeat (4) @(posedge clk);
    check({27'h0, oe_n}, 32'h1f);
    finish_test();
  end
endmodule
